// *** sram_port_defs.svh ***
// widths, reset values and timing counts for the flow-through burst sram port
`ifndef SRAM_PORT_DEFS_SVH
`define SRAM_PORT_DEFS_SVH

// array shape: 1M words of 36 bits, four lanes of 8 data bits plus one parity bit
`define ADDR_WIDTH 20
`define WORD_COUNT 1048576
`define DATA_WIDTH 32
`define LANE_COUNT 4
`define LANE_DATA_WIDTH 8
`define WORD_WIDTH 36

// sleep entry and exit, in clock cycles
`define SLEEP_ENTER_TCYC 2
`define SLEEP_EXIT_TCYC 2
`define SLEEP_ENTER_CYCLES (`SLEEP_ENTER_TCYC * 1)
`define SLEEP_EXIT_CYCLES (`SLEEP_EXIT_TCYC * 1)

// pin synchroniser depth
`define SYNC_STAGES 3

// reset values
`define DATA_RESET 32'h0000_0000
`define PARITY_RESET 4'h0
`define BURST_RESET 2'h0
`define HIGH_ADDR_RESET 18'h0_0000
`define WAIT_RESET 2'h0
// async pins at reset: {burst order, sleep, output enable} = {interleaved, awake, off}
`define ASYNC_PIN_RESET 3'h5

`endif

// *** sram_port_pkg.sv ***
// types shared by the flow-through burst sram port
package sram_port_pkg;

   typedef enum logic [1:0] {
      sleep_awake,
      sleep_entering,
      sleep_asleep,
      sleep_leaving
   } sleep_state_e;

   typedef logic [1:0] burst_low_t;
   typedef logic [1:0] wait_count_t;
   typedef logic [3:0] lane_mask_t;

endpackage : sram_port_pkg

// *** burst_counter.sv ***
// two-bit wraparound burst counter, linear or interleaved order
`timescale 1ns/100ps
`include "sram_port_defs.svh"

module burst_counter
   import sram_port_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic advance,
   input wire logic interleaved,
   input wire burst_low_t start_low,
   output burst_low_t current_low,
   output burst_low_t stepped_low
);

   burst_low_t start;
   burst_low_t beat;
   burst_low_t next_beat;

   ////////////////////////////////////////////////////////////////////////////////
   // order mapping, used for the current and the stepped address
   function automatic burst_low_t order_map(input burst_low_t s, input burst_low_t b,
                                            input logic il);
      order_map = il ? (s ^ b) : burst_low_t'(s + b);
   endfunction : order_map

   assign next_beat = burst_low_t'(beat + 2'h1);

   ////////////////////////////////////////////////////////////////////////////////
   // start value and beat count
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         start <= `BURST_RESET;
         beat <= `BURST_RESET;
      end else if (load) begin
         start <= start_low;
         beat <= `BURST_RESET;
      end else if (advance) begin
         beat <= next_beat;
      end
   end

   assign current_low = order_map(start, beat, interleaved);
   assign stepped_low = order_map(start, next_beat, interleaved);

endmodule : burst_counter

// *** flow_through_burst_sram_port.sv ***
// flow-through synchronous burst sram port, 1M x 36, common data bus
//
// Summary of operation
// - all synchronous inputs captured on rising clock
// - array of 1M 36-bit words, shared bus
// - address, enables registered when a strobe active
// - new address loads low two bits into counter
// - order input high interleaved, low linear
// - advance low steps counter during a burst
// - processor strobe ignored while first enable high
// - both strobes low, first enable low: processor strobe alone acts
// - selected only by enable pattern at load
// - byte written when its select and enable low
// - global write low writes all four bytes
// - output enable low drives, high tri-states
// - first read cycle after deselect stays tri-stated
// - tri-state on write data and while deselected
// - write data captured on the rising edge
// - sleep high enters retention, low for operation
// - read shows word at registered read address
// - linear adds beat, interleaved xors beat
// - processor-strobe write: controls taken next edge
// - two cycles to enter or leave sleep
`timescale 1ns/100ps
`include "sram_port_defs.svh"

module flow_through_burst_sram_port
   import sram_port_pkg::*;
(
   input wire logic clk,
   input wire logic reset,
   input wire logic [`ADDR_WIDTH-1:0] address,
   input wire logic chip_enable_first_n,
   input wire logic chip_enable_second,
   input wire logic chip_enable_third_n,
   input wire logic addr_strobe_processor_n,
   input wire logic addr_strobe_controller_n,
   input wire logic burst_advance_n,
   input wire logic [`LANE_COUNT-1:0] byte_lane_select_n,
   input wire logic byte_write_enable_n,
   input wire logic global_write_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic burst_order_interleaved,
   input wire logic [`DATA_WIDTH-1:0] dq_in,
   output logic [`DATA_WIDTH-1:0] dq_out,
   output logic dq_oe,
   input wire logic [`LANE_COUNT-1:0] parity_io_in,
   output logic [`LANE_COUNT-1:0] parity_io_out,
   output logic parity_io_oe,
   output logic sleep_active
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [2:0] async_raw;
   logic [2:0] async_filt;
   logic oe_n_filt;
   logic sleep_filt;
   logic order_filt;

   sleep_state_e sleep_state;
   sleep_state_e next_sleep_state;
   wait_count_t wait_count;
   logic awake;

   logic selected;
   logic [`ADDR_WIDTH-3:0] high_addr;
   logic chip_pattern_ok;
   logic proc_start;
   logic ctrl_start;
   logic new_load;
   logic continuing;
   logic advance_now;
   lane_mask_t lane_mask;
   lane_mask_t write_lanes_now;
   logic write_now;
   logic read_now;
   logic first_after_deselect;

   burst_low_t current_low;
   burst_low_t stepped_low;
   burst_low_t access_low;
   logic [`ADDR_WIDTH-1:0] access_word;

   // whole array in flip-flops; no reset, contents survive sleep
   logic [`WORD_WIDTH-1:0] mem [0:`WORD_COUNT-1];

   ////////////////////////////////////////////////////////////////////////////////
   // write lane decode, used on controller-strobe loads and burst continuations
   function automatic lane_mask_t write_lanes(input logic gw_n, input logic bwe_n,
                                              input lane_mask_t bw_n);
      if (!gw_n) begin
         write_lanes = 4'hF;
      end else if (!bwe_n) begin
         write_lanes = ~bw_n;
      end else begin
         write_lanes = 4'h0;
      end
   endfunction : write_lanes

   ////////////////////////////////////////////////////////////////////////////////
   // asynchronous pins: three stages, change accepted when stages two and three agree
   // costs three to four cycles of latency on output enable, traded for clean sampling

   assign async_raw = {burst_order_interleaved, sleep_request, output_enable_n};

   for (genvar i = 0; i < 3; i++) begin : g_sync
      localparam logic [2:0] RESET_BITS = `ASYNC_PIN_RESET;
      logic [`SYNC_STAGES-1:0] stage;
      logic filt;
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            stage <= {`SYNC_STAGES{RESET_BITS[i]}};
         end else begin
            stage <= {stage[`SYNC_STAGES-2:0], async_raw[i]};
         end
      end
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            filt <= RESET_BITS[i];
         end else if (stage[1] == stage[2]) begin
            filt <= stage[1];
         end
      end
      assign async_filt[i] = filt;
   end

   assign oe_n_filt = async_filt[0];
   assign sleep_filt = async_filt[1];
   assign order_filt = async_filt[2];

   ////////////////////////////////////////////////////////////////////////////////
   // sleep sequencing

   always_comb begin
      next_sleep_state = sleep_state;
      unique case (sleep_state)
         sleep_awake: begin
            if (sleep_filt) begin
               next_sleep_state = sleep_entering;
            end
         end
         sleep_entering: begin
            if (wait_count == 2'h1) begin
               next_sleep_state = sleep_asleep;
            end
         end
         sleep_asleep: begin
            if (!sleep_filt) begin
               next_sleep_state = sleep_leaving;
            end
         end
         sleep_leaving: begin
            if (wait_count == 2'h1) begin
               next_sleep_state = sleep_awake;
            end
         end
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sleep_state <= sleep_awake;
      end else begin
         sleep_state <= next_sleep_state;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wait_count <= `WAIT_RESET;
      end else if (sleep_state == sleep_awake && sleep_filt) begin
         wait_count <= wait_count_t'(`SLEEP_ENTER_CYCLES);
      end else if (sleep_state == sleep_asleep && !sleep_filt) begin
         wait_count <= wait_count_t'(`SLEEP_EXIT_CYCLES);
      end else if (wait_count != `WAIT_RESET) begin
         wait_count <= wait_count_t'(wait_count - 2'h1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sleep_active <= 1'h0;
      end else begin
         sleep_active <= (next_sleep_state != sleep_awake);
      end
   end

   assign awake = (sleep_state == sleep_awake);

   ////////////////////////////////////////////////////////////////////////////////
   // access decode on the sampled synchronous inputs

   // enables only matter on a load edge; between loads the registered selection rules
   assign chip_pattern_ok = !chip_enable_first_n && chip_enable_second
                            && !chip_enable_third_n;
   assign proc_start = awake && !addr_strobe_processor_n
                       && !chip_enable_first_n;
   assign ctrl_start = awake && !addr_strobe_controller_n && !proc_start;
   assign new_load = proc_start || ctrl_start;
   assign continuing = awake && !new_load && selected;
   assign advance_now = continuing && !burst_advance_n;

   assign lane_mask = write_lanes(global_write_n, byte_write_enable_n, byte_lane_select_n);

   // processor-strobe load never writes; the controls count from the next edge on
   // a controller-strobe read relies on the host holding the write controls off
   always_comb begin
      write_lanes_now = 4'h0;
      if (proc_start) begin
         write_lanes_now = 4'h0;
      end else if (ctrl_start && chip_pattern_ok) begin
         write_lanes_now = lane_mask;
      end else if (continuing) begin
         write_lanes_now = lane_mask;
      end
   end

   assign write_now = (write_lanes_now != 4'h0);
   assign read_now = !write_now && ((new_load && chip_pattern_ok) || continuing);
   assign first_after_deselect = new_load && !selected;

   assign access_low = new_load ? address[1:0] : (advance_now ? stepped_low : current_low);
   assign access_word = new_load ? address : {high_addr, access_low};

   ////////////////////////////////////////////////////////////////////////////////
   // burst counter

   burst_counter u_burst_counter (
      .clk(clk),
      .reset(reset),
      .load(new_load),
      .advance(advance_now),
      .interleaved(order_filt),
      .start_low(address[1:0]),
      .current_low(current_low),
      .stepped_low(stepped_low)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // address and selection registers

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         high_addr <= `HIGH_ADDR_RESET;
      end else if (new_load) begin
         high_addr <= address[`ADDR_WIDTH-1:2];
      end
   end

   // pending accesses are dropped on sleep entry
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         selected <= 1'h0;
      end else if (!awake) begin
         selected <= 1'h0;
      end else if (new_load) begin
         selected <= chip_pattern_ok;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // array write: bus data taken on the same edge as the controls

   always_ff @(posedge clk) begin
      for (int lane = 0; lane < `LANE_COUNT; lane++) begin
         if (write_lanes_now[lane]) begin
            mem[access_word][lane*`LANE_DATA_WIDTH +: `LANE_DATA_WIDTH]
               <= dq_in[lane*`LANE_DATA_WIDTH +: `LANE_DATA_WIDTH];
            mem[access_word][`DATA_WIDTH + lane] <= parity_io_in[lane];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path: word fetched on the address edge itself, nothing pipelined after it

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dq_out <= `DATA_RESET;
         parity_io_out <= `PARITY_RESET;
      end else if (read_now) begin
         dq_out <= mem[access_word][`DATA_WIDTH-1:0];
         parity_io_out <= mem[access_word][`WORD_WIDTH-1:`DATA_WIDTH];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bus direction

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         dq_oe <= 1'h0;
         parity_io_oe <= 1'h0;
      end else if (!read_now || first_after_deselect) begin
         dq_oe <= 1'h0;
         parity_io_oe <= 1'h0;
      end else begin
         dq_oe <= !oe_n_filt;
         parity_io_oe <= !oe_n_filt;
      end
   end

endmodule : flow_through_burst_sram_port

// *** sram_port_sva.sv ***
// concurrent checks on the ports of the flow-through burst sram port
`timescale 1ns/100ps
`include "sram_port_defs.svh"
module sram_port_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic chip_enable_first_n,
   input wire logic chip_enable_second,
   input wire logic chip_enable_third_n,
   input wire logic addr_strobe_processor_n,
   input wire logic addr_strobe_controller_n,
   input wire logic [`LANE_COUNT-1:0] byte_lane_select_n,
   input wire logic byte_write_enable_n,
   input wire logic global_write_n,
   input wire logic output_enable_n,
   input wire logic sleep_request,
   input wire logic [`DATA_WIDTH-1:0] dq_out,
   input wire logic dq_oe,
   input wire logic parity_io_oe,
   input wire logic sleep_active
);
   logic sel;
   logic [3:0] low_count;
   wire logic load = !sleep_active && (!addr_strobe_controller_n ||
      (!addr_strobe_processor_n && !chip_enable_first_n));
   wire logic pat = !chip_enable_first_n && chip_enable_second && !chip_enable_third_n;
   wire logic wr = !global_write_n || (!byte_write_enable_n && byte_lane_select_n != 4'hF);
   // selection moves only on load edges; sleep entry drops it
   always_ff @(posedge clk or posedge reset) begin
      if (reset) sel <= 1'h0;
      else if (sleep_active) sel <= 1'h0;
      else if (load) sel <= pat;
   end
   // counts edges with sleep released, saturating so it never wraps
   always_ff @(posedge clk or posedge reset) begin
      if (reset) low_count <= 4'h0;
      else if (sleep_request) low_count <= 4'h0;
      else if (low_count != 4'hF) low_count <= low_count + 4'h1;
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // oe passes a synchroniser, so it needs several edges to take effect
   sequence s_oe_off; output_enable_n [*6]; endsequence
   sequence s_asleep; sleep_active [*4]; endsequence
   a_first_read_masked: assert property (load && !(sel && pat) |=> !dq_oe)
      else $error("data driven on first read after deselect");
   a_deselect_off: assert property (!sel && !load |=> !dq_oe)
      else $error("data driven while deselected");
   a_write_data_off: assert property (sel && !load && wr |=> !dq_oe)
      else $error("data driven during a write");
   a_oe_high_off: assert property (s_oe_off |=> !dq_oe)
      else $error("data driven with output enable high");
   a_parity_oe_pair: assert property (dq_oe == parity_io_oe)
      else $error("parity and data enables differ");
   a_idle_out_held: assert property (!sel && !load |=> $stable(dq_out))
      else $error("read data changed without a read");
   a_sleep_entry: assert property (sleep_request [*7] |-> sleep_active)
      else $error("sleep not entered");
   a_sleep_min_hold: assert property ($rose(sleep_active) |-> s_asleep)
      else $error("sleep left too early");
   a_sleep_exit: assert property (low_count > 4'hB |-> !sleep_active)
      else $error("sleep not left");
endmodule : sram_port_sva

// *** bus_host.sv ***
// host model driving the synchronous bus of the sram port
`timescale 1ns/100ps
`include "sram_port_defs.svh"
module bus_host (
   input wire logic [`DATA_WIDTH-1:0] dq_out,
   input wire logic dq_oe,
   input wire logic [`LANE_COUNT-1:0] parity_io_out,
   output logic [`ADDR_WIDTH-1:0] address,
   output logic chip_enable_first_n,
   output logic chip_enable_second,
   output logic chip_enable_third_n,
   output logic addr_strobe_processor_n,
   output logic addr_strobe_controller_n,
   output logic burst_advance_n,
   output logic [`LANE_COUNT-1:0] byte_lane_select_n,
   output logic byte_write_enable_n,
   output logic global_write_n,
   output logic output_enable_n,
   output logic sleep_request,
   output logic burst_order_interleaved,
   output logic [`DATA_WIDTH-1:0] dq_in,
   output logic [`LANE_COUNT-1:0] parity_io_in
);
   logic [35:0] hdrv = 36'h0;
   // a released bus flips every cycle, so a stale word never looks valid
   assign {parity_io_in, dq_in} = dq_oe ? {parity_io_out, dq_out} : hdrv;
   // write controls and data come together; reads keep writes off
   task automatic cyc(input logic [11:0] c, input logic [19:0] a, input logic [35:0] d);
      {addr_strobe_processor_n, addr_strobe_controller_n, chip_enable_first_n,
         chip_enable_second, chip_enable_third_n, burst_advance_n, global_write_n,
         byte_write_enable_n, byte_lane_select_n} = c;
      address = a;
      hdrv = (!c[5] || !c[4]) ? d : ~hdrv;
   endtask : cyc
   task automatic set_pins(input logic oe, input logic sl, input logic mo);
      output_enable_n = oe;
      sleep_request = sl;
      burst_order_interleaved = mo;
   endtask : set_pins
   initial begin
      cyc(12'hEFF, 20'h0, 36'h0);
      set_pins(1'h0, 1'h0, 1'h1);
   end
endmodule : bus_host

// *** tb_top.sv ***
// self-checking bench for the flow-through burst sram port
`timescale 1ns/100ps
`include "sram_port_defs.svh"
module tb_top;
   localparam logic [11:0] c_idle = 12'hEFF;
   localparam logic [11:0] c_desel = 12'hAFF;
   localparam logic [11:0] c_rd_c = 12'h97F;
   localparam logic [11:0] c_rd_p = 12'h57F;
   localparam logic [11:0] c_adv = 12'hD3F;
   localparam logic [11:0] c_cont = 12'hD7F;
   logic clk = 1'h0;
   logic reset = 1'h1;
   logic [`ADDR_WIDTH-1:0] address;
   logic chip_enable_first_n, chip_enable_second, chip_enable_third_n, burst_advance_n;
   logic addr_strobe_processor_n, addr_strobe_controller_n, byte_write_enable_n;
   logic [`LANE_COUNT-1:0] byte_lane_select_n, parity_io_in, parity_io_out;
   logic global_write_n, output_enable_n, sleep_request, burst_order_interleaved;
   logic dq_oe, parity_io_oe, sleep_active;
   logic [`DATA_WIDTH-1:0] dq_in, dq_out;
   logic [35:0] mem [logic [19:0]];
   logic [15:0] lf = 16'hC0F0;
   logic sel = 1'h0;
   logic mode = 1'h1;
   logic oe_lvl = 1'h0;
   logic [1:0] start, bt;
   logic [19:0] cur, a;
   int miscompares = 0;
   int checked = 0;
   flow_through_burst_sram_port dut (.*);
   bus_host host (.*);
   always #4 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [35:0] rnd();
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
      return {lf[3:0], lf, ~lf};
   endfunction : rnd
   task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // one bus edge: drive, let the edge land, then update the model and compare
   task automatic beat(input logic [11:0] c, input logic [19:0] ad, input logic [35:0] d);
      logic proc, load, eoe;
      logic [3:0] ln;
      logic [35:0] w;
      host.cyc(c, ad, d);
      @(posedge clk);
      #1;
      proc = !c[11] && !c[9];
      load = proc || !c[10];
      ln = !c[5] ? 4'hF : (!c[4] ? ~c[3:0] : 4'h0);
      eoe = !load || sel;
      if (load) begin
         sel = !c[9] && c[8] && !c[7];
         cur = ad;
         start = ad[1:0];
         bt = 2'h0;
         if (proc) ln = 4'h0;
      end else if (sel && !c[6]) begin
         bt = bt + 2'h1;
         cur[1:0] = mode ? start ^ bt : start + bt;
      end
      if (sel && ln != 4'h0) begin
         w = mem.exists(cur) ? mem[cur] : 36'h0;
         for (int i = 0; i < 4; i++) begin
            if (ln[i]) begin
               w[8*i+:8] = d[8*i+:8];
               w[32+i] = d[32+i];
            end
         end
         mem[cur] = w;
         check("dq_oe", dq_oe, 36'h0);
         check("parity_io_oe", parity_io_oe, 36'h0);
      end else if (sel) begin
         if (mem.exists(cur)) begin
            check("word", {parity_io_out, dq_out}, mem[cur]);
         end
         check("dq_oe", dq_oe, eoe && !oe_lvl);
         check("parity_io_oe", parity_io_oe, eoe && !oe_lvl);
      end else begin
         check("dq_oe", dq_oe, 36'h0);
         check("parity_io_oe", parity_io_oe, 36'h0);
      end
   endtask : beat
   // async pins change only while deselected, then settle through the filter
   task automatic pins(input logic oe, input logic sl, input logic mo);
      beat(c_desel, 20'h0, 36'h0);
      host.set_pins(oe, sl, mo);
      oe_lvl = oe;
      mode = mo;
      repeat (6) beat(c_idle, 20'h0, 36'h0);
   endtask : pins
   task automatic wait_sleep(input logic v);
      for (int i = 0; i < 20 && sleep_active !== v; i++) begin
         @(posedge clk);
         #1;
      end
      check("sleep_active", sleep_active, v);
   endtask : wait_sleep
   task automatic complete_run();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3) @(posedge clk);
      #1;
      reset = 1'h0;
      for (int m = 1; m >= 0; m--) begin
         pins(1'h0, 1'h0, m[0]);
         a = 20'(rnd());
         beat(c_rd_p, a, rnd());
         beat(12'hD5F, a, rnd());
         repeat (3) beat(12'hD1F, a, rnd());
         pins(1'h0, 1'h0, m[0]);
         beat(c_rd_c, a, rnd());
         repeat (3) beat(c_adv, a, rnd());
      end
      beat(c_desel, a, rnd());
      beat(c_rd_p, a, rnd());
      beat(12'hD6A, a, rnd());
      beat(12'hD70, a, rnd());
      beat(12'h15F, a, rnd());
      beat(c_cont, a, rnd());
      beat(c_desel, a, rnd());
      beat(12'h95F, a, rnd());
      beat(12'h77F, 20'(rnd()), rnd());
      beat(12'h9DF, a, rnd());
      beat(c_rd_c, a, rnd());
      beat(c_cont, a, rnd());
      pins(1'h1, 1'h0, 1'h0);
      beat(c_rd_c, a, rnd());
      beat(c_cont, a, rnd());
      pins(1'h0, 1'h1, 1'h0);
      wait_sleep(1'h1);
      pins(1'h0, 1'h0, 1'h0);
      wait_sleep(1'h0);
      repeat (2) beat(c_idle, a, rnd());
      beat(c_rd_c, a, rnd());
      beat(c_cont, a, rnd());
      complete_run();
   end
   // hang guard
   initial begin
      #200000;
      miscompares++;
      complete_run();
   end
endmodule : tb_top

bind flow_through_burst_sram_port sram_port_sva chk (.*);
